// [common/hcj_pkg.sv]
// Package with constants for the high-speed chirp handshake controller
`default_nettype none

package hcj_pkg;

  // ----------------------------------------------------------------
  // Clock rate and derived timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 5000;      // 200 MHz reference clock
  localparam int unsigned FILT_TIME_PS    = 2500000;   // state_filter_time, 2.5 us
  localparam int unsigned FILT_CYC        = (FILT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PHY_PERIOD_PS   = 16667;     // 60 MHz transceiver clock
  localparam int unsigned SETUP_PHY_CLKS  = 5;         // mode setup ahead of tx valid
  localparam int unsigned SETUP_CYC       = (SETUP_PHY_CLKS * PHY_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CHIRP_TIME_US   = 1000;      // device chirp, least
  localparam int unsigned CHIRP_CYC       = (CHIRP_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned HOST_WAIT_US    = 2000;      // search window for host chirps
  localparam int unsigned HOST_WAIT_CYC   = (HOST_WAIT_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned DEADLINE_US     = 5500;      // 10 ms budget less a 4.5 ms start lag
  // Scaled per microsecond first: the product in picoseconds overflows 32 bits
  localparam int unsigned DEADLINE_CYC    = DEADLINE_US * (1000000 / CLK_PERIOD_PS);
  localparam int unsigned PHY_CHIRP_EDGES = 66000;     // chirp length in 60 MHz cycles
  localparam int unsigned CHIRP_COUNT_HS  = 4;         // K-J-K-J

  localparam int unsigned FILT_W = 10;
  localparam int unsigned CNT_W  = 22;

  // ----------------------------------------------------------------
  // Transceiver encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] LS_SE0        = 2'h0;
  localparam logic [1:0] LS_J          = 2'h1;
  localparam logic [1:0] LS_K          = 2'h2;
  localparam logic [1:0] OPM_NORMAL    = 2'h0;
  localparam logic [1:0] OPM_NO_STUFF  = 2'h2;
  localparam logic       SPEED_FS      = 1'h1;
  localparam logic       SPEED_HS      = 1'h0;
  localparam logic       TERM_FS       = 1'h1;
  localparam logic       TERM_HS       = 1'h0;
  localparam logic [7:0] TX_ZERO       = 8'h00;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam int unsigned CTRL_START   = 0;
  localparam int unsigned CTRL_SUSPEND = 1;
  localparam int unsigned CTRL_ABORT   = 2;
  localparam int unsigned ST_HS        = 0;
  localparam int unsigned ST_FS_BACK   = 1;
  localparam int unsigned ST_BUSY      = 2;
  localparam int unsigned ST_SUSP      = 3;
  localparam int unsigned ST_WOKE      = 4;
  localparam int unsigned ST_COUNT_LSB = 8;
  localparam int unsigned ST_STATE_LSB = 16;

  typedef enum logic [6:0] {
    HCJ_IDLE     = 7'b0000001,
    HCJ_SETUP    = 7'b0000010,
    HCJ_WAIT_CLK = 7'b0000100,
    HCJ_CHIRP    = 7'b0001000,
    HCJ_LISTEN   = 7'b0010000,
    HCJ_HS_DONE  = 7'b0100000,
    HCJ_FS_BACK  = 7'b1000000
  } hcj_state_t;

endpackage : hcj_pkg

`default_nettype wire

// [logic/hcj_state_filter.sv]
// Line state filter confirming a state held for the filter time
`timescale 1ns/1ps
`default_nettype none

module hcj_state_filter (
  input  wire logic       i_clk,        // Reference clock
  input  wire logic       i_rst_b,      // Async reset, active low
  input  wire logic       i_clear,      // Restart filter
  input  wire logic [1:0] i_line_state, // Sampled bus line state
  output logic            o_confirm,    // One-cycle confirm pulse
  output logic [1:0]      o_state       // Confirmed state
);

  logic [1:0]                  last_state;
  logic [hcj_pkg::FILT_W-1:0]  stable_cnt;
  logic                        fired;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      last_state <= hcj_pkg::LS_SE0;
    end else begin
      last_state <= i_line_state;
    end
  end

  // Any change restarts the count
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stable_cnt <= '0;
      fired      <= 1'b0;
      o_confirm  <= 1'b0;
      o_state    <= hcj_pkg::LS_SE0;
    end else if (i_clear || i_line_state != last_state) begin
      stable_cnt <= '0;
      fired      <= 1'b0;
      o_confirm  <= 1'b0;
    end else if (!fired && stable_cnt == hcj_pkg::FILT_W'(hcj_pkg::FILT_CYC - 2)) begin
      fired      <= 1'b1;                       // Held for 150 phy clocks' worth
      o_confirm  <= 1'b1;
      o_state    <= i_line_state;
    end else begin
      o_confirm  <= 1'b0;
      if (!fired) begin
        stable_cnt <= stable_cnt + 1'b1;
      end
    end
  end

endmodule : hcj_state_filter

`default_nettype wire

// [logic/hcj_chirp_ctrl.sv]
// Link-side controller for the high-speed chirp detection handshake
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Handshake starts with full-speed select, full-speed terminations, pull-up on.
// - Chirp: no-stuff mode, high-speed select, all-zero data transmitted.
// - The no-stuff, no-NRZI operating mode is code 10.
// - Device chirp lasts at least 1.0 ms and ends by 7.0 ms.
// - Non-suspend case: chirp starts before 6.0 ms.
// - After own chirp, expect host chirp K within 100 us, then alternation.
// - Line state transitions step the machine; a chirp counter counts states.
// - Confirm each chirp state by holding it 2.5 us (150 phy clocks).
// - After K-J-K-J, select high-speed terminations within 500 us.
// - High-speed switch completes no later than 10 ms after reset start.
// - Without host chirps, return speed select to full-speed and wait.
// - J to SE0 while suspended releases suspend input combinationally.
// - From suspend, hold chirp for 66000 transceiver clock cycles.
// - From suspend, chirp starts before 5.8 ms and ends before 7.0 ms.
// - From suspend, time host chirp search likewise, then finish normally; the code times that search in reference clocks either way.
module hcj_chirp_ctrl #(
  parameter int unsigned CHIRP_CYC       = hcj_pkg::CHIRP_CYC,       // Device chirp length
  parameter int unsigned HOST_WAIT_CYC   = hcj_pkg::HOST_WAIT_CYC,   // Host chirp search window
  parameter int unsigned DEADLINE_CYC    = hcj_pkg::DEADLINE_CYC,    // Handshake hard stop
  parameter int unsigned PHY_CHIRP_EDGES = hcj_pkg::PHY_CHIRP_EDGES  // Chirp length in phy clocks
) (
  input  wire logic        I_REF_CLK,                // 200 MHz clock
  input  wire logic        I_RST_B,                  // Async reset, active low
  input  wire logic        PSEL,                     // APB select
  input  wire logic        PENABLE,                  // APB enable
  input  wire logic        PWRITE,                   // APB direction
  input  wire logic [11:0] PADDR,                    // APB address
  input  wire logic [31:0] PWDATA,                   // APB write data
  output logic             PREADY,                   // APB ready
  output logic [31:0]      PRDATA,                   // APB read data
  output logic             PSLVERR,                  // APB error
  input  wire logic [1:0]  I_BUS_LINE_STATE,         // Transceiver line state
  input  wire logic        I_PHY_CLOCK_60,           // Transceiver clock, sampled
  output logic             O_SPEED_SELECT,           // 1 full-speed, 0 high-speed
  output logic             O_TERMINATION_SELECT,     // 1 full-speed, 0 high-speed
  output logic [1:0]       O_OPERATING_MODE_SELECT,  // Operating mode code
  output logic             O_TX_VALID,               // Transmit valid
  output logic [7:0]       O_TX_DATA,                // Transmit data
  output logic             O_SUSPEND_ACTIVE_LOW      // Suspend, active low
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  hcj_pkg::hcj_state_t      state;
  hcj_pkg::hcj_state_t      next_state;
  logic [hcj_pkg::CNT_W-1:0] phase_cnt;
  logic [hcj_pkg::CNT_W-1:0] deadline_cnt;
  logic [16:0]               edge_cnt;
  logic [2:0]                chirp_count;
  logic [1:0]                prev_confirmed;
  logic                      from_suspend;
  logic                      suspend_req;
  logic                      woke;
  logic                      last_was_j;
  logic                      wake_now;
  logic                      phy_clk_q;
  logic                      phy_edge;
  logic                      start_req;
  logic                      abort_req;
  logic                      filt_confirm;
  logic [1:0]                filt_state;
  logic                      apb_access;
  logic                      apb_commit;
  logic                      addr_ok;
  logic                      hs_flag;
  logic                      fs_flag;

  // ----------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------
  assign apb_access = PSEL && PENABLE && !PREADY;
  assign apb_commit = PSEL && PENABLE && PREADY;
  assign addr_ok    = (PADDR == hcj_pkg::ADDR_CTRL) || (PADDR == hcj_pkg::ADDR_STATUS);
  assign start_req  = apb_commit && PWRITE && PADDR == hcj_pkg::ADDR_CTRL && PWDATA[hcj_pkg::CTRL_START];
  assign abort_req  = apb_commit && PWRITE && PADDR == hcj_pkg::ADDR_CTRL && PWDATA[hcj_pkg::CTRL_ABORT];

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (apb_access) begin
      PREADY  <= 1'b1;
      PSLVERR <= !addr_ok;
      PRDATA  <= 32'h00000000;
      if (!PWRITE && PADDR == hcj_pkg::ADDR_CTRL) begin
        PRDATA[hcj_pkg::CTRL_SUSPEND] <= suspend_req;
      end else if (!PWRITE && PADDR == hcj_pkg::ADDR_STATUS) begin
        PRDATA[hcj_pkg::ST_HS]                              <= hs_flag;
        PRDATA[hcj_pkg::ST_FS_BACK]                         <= fs_flag;
        PRDATA[hcj_pkg::ST_BUSY]                            <= state != hcj_pkg::HCJ_IDLE;
        PRDATA[hcj_pkg::ST_SUSP]                            <= !O_SUSPEND_ACTIVE_LOW;
        PRDATA[hcj_pkg::ST_WOKE]                            <= woke;
        PRDATA[hcj_pkg::ST_COUNT_LSB +: 3]                  <= chirp_count;
        PRDATA[hcj_pkg::ST_STATE_LSB +: $bits(state)]       <= state;
      end
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Suspend control and wake on J to SE0
  // ----------------------------------------------------------------
  // Wake term is combinational on purpose: no clock is promised here
  assign wake_now = suspend_req && last_was_j && I_BUS_LINE_STATE == hcj_pkg::LS_SE0;

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      last_was_j <= 1'b0;
    end else begin
      last_was_j <= I_BUS_LINE_STATE == hcj_pkg::LS_J;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      suspend_req <= 1'b0;
      woke        <= 1'b0;
    end else if (wake_now) begin
      suspend_req <= 1'b0;
      woke        <= 1'b1;
    end else if (apb_commit && PWRITE && PADDR == hcj_pkg::ADDR_CTRL) begin
      suspend_req <= PWDATA[hcj_pkg::CTRL_SUSPEND];
      woke        <= woke && !PWDATA[hcj_pkg::CTRL_SUSPEND];
    end
  end

  assign O_SUSPEND_ACTIVE_LOW = !suspend_req || wake_now;

  // ----------------------------------------------------------------
  // Transceiver clock edges
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      phy_clk_q <= 1'b0;
    end else begin
      phy_clk_q <= I_PHY_CLOCK_60;
    end
  end

  // Clock held still until usable, so each edge counts
  assign phy_edge = I_PHY_CLOCK_60 && !phy_clk_q;

  // ----------------------------------------------------------------
  // Chirp state filter
  // ----------------------------------------------------------------
  hcj_state_filter u_filter (
    .i_clk        (I_REF_CLK),
    .i_rst_b      (I_RST_B),
    .i_clear      (state != hcj_pkg::HCJ_LISTEN),
    .i_line_state (I_BUS_LINE_STATE),
    .o_confirm    (filt_confirm),
    .o_state      (filt_state)
  );

  // ----------------------------------------------------------------
  // Handshake sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      hcj_pkg::HCJ_IDLE: begin
        if (wake_now || woke && start_req) begin
          next_state = hcj_pkg::HCJ_WAIT_CLK;
        end else if (start_req) begin
          next_state = hcj_pkg::HCJ_SETUP;
        end
      end
      hcj_pkg::HCJ_WAIT_CLK: begin
        if (phy_edge) begin
          next_state = hcj_pkg::HCJ_SETUP;
        end
      end
      hcj_pkg::HCJ_SETUP: begin
        if (phase_cnt == hcj_pkg::CNT_W'(hcj_pkg::SETUP_CYC - 1)) begin
          next_state = hcj_pkg::HCJ_CHIRP;
        end
      end
      hcj_pkg::HCJ_CHIRP: begin
        if (from_suspend ? edge_cnt == 17'(PHY_CHIRP_EDGES)
                         : phase_cnt == hcj_pkg::CNT_W'(CHIRP_CYC - 1)) begin
          next_state = hcj_pkg::HCJ_LISTEN;
        end
      end
      hcj_pkg::HCJ_LISTEN: begin
        if (chirp_count == 3'(hcj_pkg::CHIRP_COUNT_HS)) begin
          next_state = hcj_pkg::HCJ_HS_DONE;
        end else if (phase_cnt == hcj_pkg::CNT_W'(HOST_WAIT_CYC - 1)
                     || deadline_cnt == hcj_pkg::CNT_W'(DEADLINE_CYC - 1)) begin
          next_state = hcj_pkg::HCJ_FS_BACK;
        end
      end
      hcj_pkg::HCJ_HS_DONE,
      hcj_pkg::HCJ_FS_BACK: begin
        next_state = hcj_pkg::HCJ_FS_BACK;
        if (state == hcj_pkg::HCJ_HS_DONE) begin
          next_state = hcj_pkg::HCJ_HS_DONE;
        end
      end
      default: begin
        next_state = hcj_pkg::HCJ_IDLE;
      end
    endcase
    if (abort_req) begin
      next_state = hcj_pkg::HCJ_IDLE;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state <= hcj_pkg::HCJ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Phase timer restarts on each state change
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      phase_cnt <= '0;
    end else if (next_state != state) begin
      phase_cnt <= '0;
    end else if (phase_cnt != '1) begin
      phase_cnt <= phase_cnt + 1'b1;
    end
  end

  // Runs from handshake start; chirp begins after the setup phase, well inside 6 ms
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      deadline_cnt <= '0;
    end else if (state == hcj_pkg::HCJ_IDLE) begin
      deadline_cnt <= '0;
    end else if (deadline_cnt != '1) begin
      deadline_cnt <= deadline_cnt + 1'b1;
    end
  end

  // From-suspend mode latched at start; chirp timed in phy clocks
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      from_suspend <= 1'b0;
      edge_cnt     <= '0;
    end else begin
      if (state == hcj_pkg::HCJ_IDLE) begin
        from_suspend <= next_state == hcj_pkg::HCJ_WAIT_CLK;
      end
      if (state != hcj_pkg::HCJ_CHIRP) begin
        edge_cnt <= '0;
      end else if (phy_edge && edge_cnt != 17'(PHY_CHIRP_EDGES)) begin
        edge_cnt <= edge_cnt + 1'b1;
      end
    end
  end

  // Chirp counter: first K, then alternate only
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      chirp_count    <= '0;
      prev_confirmed <= hcj_pkg::LS_J;
    end else if (state != hcj_pkg::HCJ_LISTEN && state != hcj_pkg::HCJ_HS_DONE
                 && state != hcj_pkg::HCJ_FS_BACK) begin
      chirp_count    <= '0;
      prev_confirmed <= hcj_pkg::LS_J;
    end else if (state == hcj_pkg::HCJ_LISTEN && filt_confirm && filt_state != prev_confirmed
                 && (filt_state == hcj_pkg::LS_K || filt_state == hcj_pkg::LS_J)) begin
      chirp_count    <= chirp_count + 1'b1;
      prev_confirmed <= filt_state;
    end
  end

  // Sticky outcome flags, cleared by a new start
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      hs_flag <= 1'b0;
      fs_flag <= 1'b0;
    end else if (next_state == hcj_pkg::HCJ_HS_DONE) begin
      hs_flag <= 1'b1;
    end else if (next_state == hcj_pkg::HCJ_FS_BACK) begin
      fs_flag <= 1'b1;
    end else if (start_req || wake_now) begin
      hs_flag <= 1'b0;
      fs_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transceiver control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_SPEED_SELECT          <= hcj_pkg::SPEED_FS;
      O_TERMINATION_SELECT    <= hcj_pkg::TERM_FS;
      O_OPERATING_MODE_SELECT <= hcj_pkg::OPM_NORMAL;
      O_TX_VALID              <= 1'b0;
      O_TX_DATA               <= hcj_pkg::TX_ZERO;
    end else begin
      O_TX_DATA <= hcj_pkg::TX_ZERO;
      unique case (next_state)
        hcj_pkg::HCJ_SETUP, hcj_pkg::HCJ_CHIRP, hcj_pkg::HCJ_LISTEN: begin
          O_SPEED_SELECT          <= hcj_pkg::SPEED_HS;
          O_TERMINATION_SELECT    <= hcj_pkg::TERM_FS;
          O_OPERATING_MODE_SELECT <= hcj_pkg::OPM_NO_STUFF;
          O_TX_VALID              <= next_state == hcj_pkg::HCJ_CHIRP;
        end
        hcj_pkg::HCJ_HS_DONE: begin
          O_SPEED_SELECT          <= hcj_pkg::SPEED_HS;
          O_TERMINATION_SELECT    <= hcj_pkg::TERM_HS;
          O_OPERATING_MODE_SELECT <= hcj_pkg::OPM_NORMAL;
          O_TX_VALID              <= 1'b0;
        end
        default: begin
          O_SPEED_SELECT          <= hcj_pkg::SPEED_FS;
          O_TERMINATION_SELECT    <= hcj_pkg::TERM_FS;
          O_OPERATING_MODE_SELECT <= hcj_pkg::OPM_NORMAL;
          O_TX_VALID              <= 1'b0;
        end
      endcase
    end
  end

endmodule : hcj_chirp_ctrl

`default_nettype wire

// [verif/hcj_phy_model.sv]
// Transceiver stand-in: reported line state and 60 MHz clock
`timescale 1ns/1ps
`default_nettype none

module hcj_phy_model #(
  parameter int WAKE_NS = 400  // Clock restart delay, well inside 5.6 ms
) (
  input  wire logic       i_suspend_active_low, // Suspend, active low
  input  wire logic       i_tx_valid,           // Transmit valid
  input  wire logic [7:0] i_tx_data,            // Transmit data
  input  wire logic [1:0] i_host_ls,            // Line state made by host
  output logic [1:0]      o_line_state,         // Reported line state
  output logic            o_clk                 // 60 MHz clock
);
  logic run = 1'b1;

  // Own all-zero transmit shows as K over the host
  assign o_line_state = (i_tx_valid && i_tx_data == 8'h00) ? 2'h2 : i_host_ls;

  // Clock still in suspend, back only once usable
  always @(i_suspend_active_low) begin
    if (!i_suspend_active_low)
      run = 1'b0;
    else
      #(WAKE_NS) run = 1'b1;
  end

  initial o_clk = 1'b0;
  always #8.333 o_clk = run ? ~o_clk : 1'b0;
endmodule : hcj_phy_model

`default_nettype wire

// [verif/hcj_chirp_ctrl_monitor.sv]
// Concurrent checks on the chirp handshake controller outputs
`timescale 1ns/1ps
`default_nettype none

module hcj_chirp_ctrl_monitor #(
  parameter int unsigned CHIRP_CYC       = 200,  // Device chirp length
  parameter int unsigned PHY_CHIRP_EDGES = 50,   // Chirp length in phy clocks
  parameter int unsigned HOST_WAIT_CYC   = 4000  // Host chirp search window
) (
  input wire logic       I_REF_CLK,               // Clock
  input wire logic       I_RST_B,                 // Reset, active low
  input wire logic [1:0] I_BUS_LINE_STATE,        // Line state
  input wire logic       I_PHY_CLOCK_60,          // Phy clock
  input wire logic       O_SPEED_SELECT,          // Speed select
  input wire logic       O_TERMINATION_SELECT,    // Termination select
  input wire logic [1:0] O_OPERATING_MODE_SELECT, // Operating mode
  input wire logic       O_TX_VALID,              // Transmit valid
  input wire logic [7:0] O_TX_DATA,               // Transmit data
  input wire logic       O_SUSPEND_ACTIVE_LOW     // Suspend, active low
);
  logic [21:0] n_tx;
  logic [21:0] n_since;
  logic [16:0] n_edge;
  logic        clk_q;
  logic        from_susp;

  // ----------------------------------------------------------------
  // Chirp meters
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      n_tx   <= '0;
      n_edge <= '0;
      clk_q  <= 1'b0;
    end else begin
      clk_q  <= I_PHY_CLOCK_60;
      n_tx   <= O_TX_VALID ? n_tx + 22'h1 : '0;
      n_edge <= O_TX_VALID ? n_edge + 17'(I_PHY_CLOCK_60 && !clk_q) : '0;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      n_since   <= '0;
      from_susp <= 1'b0;
    end else begin
      n_since   <= $fell(O_TX_VALID) ? '0 : n_since + 22'h1;
      from_susp <= !O_SUSPEND_ACTIVE_LOW ? 1'b1 : ($fell(O_TX_VALID) ? 1'b0 : from_susp);
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);

  entry_fs_a: assert property ($fell(O_SPEED_SELECT) |-> O_TERMINATION_SELECT && !O_TX_VALID)
    else $error("speed dropped without full-speed terminations");
  setup_lead_a: assert property ($fell(O_SPEED_SELECT) |-> (!O_TX_VALID) [*8])
    else $error("transmit valid too soon after mode setup");
  chirp_mode_a: assert property (O_TX_VALID |-> O_OPERATING_MODE_SELECT == 2'h2 && !O_SPEED_SELECT
    && O_TX_DATA == 8'h00) else $error("chirp sent in wrong mode or data");
  chirp_len_a: assert property ($fell(O_TX_VALID) |-> (from_susp ? n_edge >= PHY_CHIRP_EDGES
    : n_tx == CHIRP_CYC)) else $error("device chirp length wrong");
  hs_term_a: assert property ($fell(O_TERMINATION_SELECT) |-> !O_SPEED_SELECT
    && O_OPERATING_MODE_SELECT == 2'h0 && !O_TX_VALID) else $error("bad state at high-speed switch");
  filter_min_a: assert property ($fell(O_TERMINATION_SELECT) |-> n_since >= 4 * hcj_pkg::FILT_CYC)
    else $error("high-speed switch before four filtered chirps");
  host_wait_a: assert property ($rose(O_SPEED_SELECT) && $past(O_TERMINATION_SELECT) |->
    n_since + 2 >= HOST_WAIT_CYC && n_since <= HOST_WAIT_CYC + 4) else $error("fallback timing wrong");
  wake_comb_a: assert property ((!O_SUSPEND_ACTIVE_LOW && I_BUS_LINE_STATE == 2'h1) ##1
    (I_BUS_LINE_STATE == 2'h0) |-> O_SUSPEND_ACTIVE_LOW) else $error("suspend not released at once");
endmodule : hcj_chirp_ctrl_monitor

`default_nettype wire

// [verif/test_hcj_chirp_ctrl.sv]
// Testbench for the chirp handshake controller
`timescale 1ns/1ps
`default_nettype none

module test_hcj_chirp_ctrl;
  localparam int CHIRP = 200;
  localparam int HWAIT = 4000;
  localparam int EDGES = 50;

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0]  host_ls = 2'h0;
  logic [31:0] prdata, rdv;
  logic [1:0]  ls, opm;
  logic [7:0]  txd;
  logic        pready, pslverr, phy_clk, spd, term, txv, sus_b, err;
  int          n, n_errors = 0, checked = 0;

  always #2.5 clk = ~clk;

  hcj_chirp_ctrl #(.CHIRP_CYC(CHIRP), .HOST_WAIT_CYC(HWAIT), .DEADLINE_CYC(20000), .PHY_CHIRP_EDGES(EDGES)) dut_u (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .I_BUS_LINE_STATE(ls),
    .I_PHY_CLOCK_60(phy_clk), .O_SPEED_SELECT(spd), .O_TERMINATION_SELECT(term),
    .O_OPERATING_MODE_SELECT(opm), .O_TX_VALID(txv), .O_TX_DATA(txd), .O_SUSPEND_ACTIVE_LOW(sus_b));

  hcj_phy_model phy_u (.i_suspend_active_low(sus_b), .i_tx_valid(txv), .i_tx_data(txd),
    .i_host_ls(host_ls), .o_line_state(ls), .o_clk(phy_clk));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Idle cycle after each transfer keeps strobes from being driven twice at one edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    chk("apb wait", 32'h2, k);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wait_for(input int sel, input logic v);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((sel == 0 ? txv : sel == 1 ? term : spd) !== v && n < 30000);
  endtask : wait_for

  // Non-K first state must be ignored, then K-J-K-J
  task automatic host_chirps();
    logic [1:0] seq [5] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h1};
    foreach (seq[i]) begin
      host_ls <= seq[i];
      repeat (600) @(posedge clk);
    end
    host_ls <= 2'h0;
  endtask : host_chirps

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  initial begin
    #(5 * 60000);
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("speed", 1, spd);
    chk("term", 1, term);
    apb(0, 12'h004, 0);
    chk("idle status", 32'h0001_0000, rdv & 32'h007F_0003);
    apb(0, 12'h008, 0);
    chk("unmapped err", 1, err);
    $display("test reset done");
    apb(1, 12'h000, 32'h1);
    wait_for(0, 1);
    chk("chirp speed", 0, spd);
    chk("chirp operating_mode_select", 2, opm);
    wait_for(0, 0);
    chk("chirp length", CHIRP, n);
    host_chirps();
    chk("hs term", 0, term);
    chk("hs operating_mode_select", 0, opm);
    apb(0, 12'h004, 0);
    chk("hs status", 32'h0020_0401, rdv & 32'h007F_0701);
    $display("test normal done");
    apb(1, 12'h000, 32'h4);
    apb(1, 12'h000, 32'h1);
    wait_for(0, 1);
    wait_for(0, 0);
    wait_for(2, 1);
    chk("fallback wait", 1, n + 2 >= HWAIT && n <= HWAIT + 4);
    apb(0, 12'h004, 0);
    chk("fallback status", 32'h0040_0002, rdv & 32'h007F_0002);
    $display("test fallback done");
    apb(1, 12'h000, 32'h4);
    host_ls <= 2'h1;
    apb(1, 12'h000, 32'h2);
    chk("suspended", 0, sus_b);
    host_ls <= 2'h0;
    #1;
    chk("wake same cycle", 1, sus_b);
    wait_for(0, 1);
    wait_for(0, 0);
    chk("suspend chirp", 1, 3 * n >= 10 * (EDGES - 1));
    host_chirps();
    chk("resumed hs term", 0, term);
    apb(0, 12'h004, 0);
    chk("woke status", 32'h0020_0415, rdv & 32'h007F_071F);
    $display("test suspend done");
    print_verdict();
  end
endmodule : test_hcj_chirp_ctrl

bind hcj_chirp_ctrl hcj_chirp_ctrl_monitor #(.CHIRP_CYC(CHIRP_CYC), .PHY_CHIRP_EDGES(PHY_CHIRP_EDGES),
  .HOST_WAIT_CYC(HOST_WAIT_CYC)) mon_u (.I_REF_CLK, .I_RST_B, .I_BUS_LINE_STATE, .I_PHY_CLOCK_60,
  .O_SPEED_SELECT, .O_TERMINATION_SELECT, .O_OPERATING_MODE_SELECT, .O_TX_VALID, .O_TX_DATA,
  .O_SUSPEND_ACTIVE_LOW);

`default_nettype wire
